// ---- hdl/fetch_pipeline_pc_control.sv ----
// instruction fetch, execute sequencing and program counter with apb access
`timescale 1ns/1ns
module fetch_pipeline_pc_control
    import fetch_pkg::*;
(
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // program memory
    output logic      [PC_W-1:0] pm_addr,
    output logic                 pm_rd,
    input  wire logic [15:0]     pm_data,
    // interrupt request pin and acknowledge
    input  wire logic            irq_pin,
    output logic                 int_ack,
    // phase strobes, one-hot
    output logic      [3:0]      instruction_phases
);

    typedef struct packed {
        phase_t                          phase;
        logic [3:0]                      ph_oh;
        logic [PC_W-1:0]                 pc;
        logic [PC_W-1:0]                 fetch_addr;
        logic [PC_W-1:0]                 exec_addr;
        logic [15:0]                     ir;
        logic                            ir_valid;
        logic                            pm_rd;
        logic [7:0]                      acc;
        logic                            zero;
        logic [STK_DEPTH-1:0][PC_W-1:0]  stk;
        logic [STK_IW-1:0]               stk_top;
        logic [STK_IW:0]                 stk_cnt;
        logic [1:0]                      ctrl;
        logic                            pcl_wr_pend;
        logic [7:0]                      pcl_wdata;
        logic                            irq_s1;
        logic                            irq_s2;
        logic                            irq_last;
        logic                            irq_pend;
        logic                            int_ack;
        logic [31:0]                     prdata;
        logic                            pready;
        logic                            pslverr;
    } state_t;

    state_t st_reg;
    state_t st_next;

    ////////////////////////////////////////////////////////////////////
    // decode helpers
    op_t       op;
    alu_fn_t   fn;
    logic [7:0] imm;
    logic [7:0] alu_res;
    logic       skip_hit;

    assign op  = op_t'(st_reg.ir[15:13]);
    assign fn  = alu_fn_t'(st_reg.ir[11:8]);
    assign imm = st_reg.ir[7:0];

    // eight bit datapath shared by arithmetic, logic and rotate operations
    always_comb begin
        unique case (fn)
            FN_LOAD: alu_res = imm;
            FN_ADD:  alu_res = st_reg.acc + imm;
            FN_SUB:  alu_res = st_reg.acc - imm;
            FN_AND:  alu_res = st_reg.acc & imm;
            FN_OR:   alu_res = st_reg.acc | imm;
            FN_XOR:  alu_res = st_reg.acc ^ imm;
            FN_RR:   alu_res = {st_reg.acc[0], st_reg.acc[7:1]};
            FN_RL:   alu_res = {st_reg.acc[6:0], st_reg.acc[7]};
            FN_INC:  alu_res = st_reg.acc + 8'h01;
            FN_DEC:  alu_res = st_reg.acc - 8'h01;
            default: alu_res = st_reg.acc;
        endcase
    end

    // branch decision from the alu zero flag
    assign skip_hit = (op == OP_SKZ  &&  st_reg.zero) ||
                      (op == OP_SKNZ && !st_reg.zero);

    ////////////////////////////////////////////////////////////////////
    // apb decode
    logic apb_setup;
    logic apb_done;
    logic mapped;
    logic [31:0] rd_val;

    assign apb_setup = psel && !penable;
    assign apb_done  = psel && penable && st_reg.pready;
    assign mapped    = paddr == OFS_PCL || paddr == OFS_CTRL ||
                       paddr == OFS_STATUS || paddr == OFS_ACC;

    always_comb begin
        rd_val = 32'h00000000;
        unique case (paddr)
            // only the low byte of the counter is visible
            OFS_PCL:  rd_val[7:0] = st_reg.exec_addr[7:0];
            OFS_CTRL: rd_val[1:0] = st_reg.ctrl;
            OFS_STATUS: begin
                rd_val[PC_W-1:0] = st_reg.exec_addr;
                rd_val[STAT_PHASE_POS +: 2] = st_reg.phase;
                rd_val[STAT_CNT_POS +: STK_IW+1] = st_reg.stk_cnt;
                rd_val[STAT_ZERO_POS] = st_reg.zero;
            end
            OFS_ACC:  rd_val[7:0] = st_reg.acc;
            default:  rd_val = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    logic [STK_IW-1:0] push_idx;
    logic              irq_edge;
    logic              irq_take;
    logic              flush;

    assign push_idx = st_reg.stk_top + STK_IW'(1);
    assign irq_edge = st_reg.irq_s2 && !st_reg.irq_last;

    always_comb begin
        st_next = st_reg;
        st_next.irq_s1   = irq_pin;
        st_next.irq_s2   = st_reg.irq_s1;
        st_next.irq_last = st_reg.irq_s2;
        st_next.int_ack  = 1'b0;
        st_next.pm_rd    = 1'b0;
        irq_take = 1'b0;
        flush    = 1'b0;

        // register bus, zero wait state answer one cycle after setup
        st_next.pready  = apb_setup;
        st_next.pslverr = apb_setup && !mapped;
        st_next.prdata  = apb_setup && !pwrite ? rd_val : 32'h00000000;
        if (apb_done && pwrite) begin
            if (paddr == OFS_PCL) begin
                st_next.pcl_wr_pend = 1'b1;
                st_next.pcl_wdata   = pwdata[7:0];
            end
            if (paddr == OFS_CTRL)
                st_next.ctrl = pwdata[1:0];
        end

        if (st_reg.ctrl[CTRL_RUN_BIT]) begin
            st_next.phase = phase_t'(st_reg.phase + 2'd1);
            st_next.ph_oh = {st_reg.ph_oh[2:0], st_reg.ph_oh[3]};
            unique case (st_reg.phase)
                PH_FETCH: begin
                    // fetch the next word while the current one executes
                    st_next.fetch_addr = st_reg.pc;
                    st_next.pm_rd      = 1'b1;
                    st_next.pc         = st_reg.pc + PC_W'(1);
                end
                PH_DEC, PH_EXE: begin
                    // operands settle, nothing commits yet
                end
                PH_DONE: begin
                    if (st_reg.ir_valid) begin
                        unique case (op)
                            OP_ALU: begin
                                st_next.acc  = alu_res;
                                st_next.zero = alu_res == 8'h00;
                            end
                            OP_JUMP: begin
                                st_next.pc = st_reg.ir[PC_W-1:0];
                                flush = 1'b1;
                            end
                            OP_CALL: begin
                                // the discarded prefetch is the return
                                st_next.stk[push_idx] = st_reg.fetch_addr;
                                st_next.stk_top = push_idx;
                                if (st_reg.stk_cnt != STK_DEPTH)
                                    st_next.stk_cnt = st_reg.stk_cnt + 1'b1;
                                st_next.pc = st_reg.ir[PC_W-1:0];
                                flush = 1'b1;
                            end
                            OP_RET, OP_INTERRUPT_RETURN_INSTR: begin
                                st_next.pc = st_reg.stk[st_reg.stk_top];
                                st_next.stk_top = st_reg.stk_top - 1'b1;
                                if (st_reg.stk_cnt != '0)
                                    st_next.stk_cnt = st_reg.stk_cnt - 1'b1;
                                if (op == OP_INTERRUPT_RETURN_INSTR)
                                    st_next.ctrl[CTRL_IEN_BIT] = 1'b1;
                                flush = 1'b1;
                            end
                            OP_SKZ, OP_SKNZ: begin
                                flush = skip_hit;
                            end
                            default: begin
                            end
                        endcase
                    end
                    // interrupt waits for a free stack level and no branch
                    irq_take = st_reg.irq_pend && !flush &&
                               st_reg.ctrl[CTRL_IEN_BIT] &&
                               st_reg.stk_cnt != STK_DEPTH;
                    if (irq_take) begin
                        st_next.stk[push_idx] = st_reg.fetch_addr;
                        st_next.stk_top = push_idx;
                        st_next.stk_cnt = st_reg.stk_cnt + 1'b1;
                        st_next.pc = IRQ_VECTOR;
                        st_next.ctrl[CTRL_IEN_BIT] = 1'b0;
                        st_next.int_ack = 1'b1;
                        flush = 1'b1;
                    end
                    // software jump within the page of the current word
                    if (st_reg.pcl_wr_pend) begin
                        st_next.pc = {st_reg.exec_addr[PC_W-1:8],
                                      st_reg.pcl_wdata};
                        st_next.pcl_wr_pend = 1'b0;
                        flush = 1'b1;
                    end
                    // prefetched word becomes current, or a dummy slot
                    st_next.ir        = pm_data;
                    st_next.exec_addr = st_reg.fetch_addr;
                    st_next.ir_valid  = !flush;
                end
                default: begin
                end
            endcase
        end

        // a new edge in the ack cycle is kept, set wins over clear
        if (irq_take)
            st_next.irq_pend = 1'b0;
        if (irq_edge)
            st_next.irq_pend = 1'b1;
        // a write landing with the pending jump is kept for the next cycle
        if (apb_done && pwrite && paddr == OFS_PCL)
            st_next.pcl_wr_pend = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg             <= '0;
            st_reg.phase       <= PH_FETCH;
            st_reg.ph_oh       <= 4'h1;
            st_reg.pc          <= RESET_VECTOR;
            st_reg.fetch_addr  <= RESET_VECTOR;
            st_reg.exec_addr   <= RESET_VECTOR;
            st_reg.ctrl        <= CTRL_RESET;
            st_reg.stk_top     <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from state
    assign prdata             = st_reg.prdata;
    assign pready             = st_reg.pready;
    assign pslverr            = st_reg.pslverr;
    assign pm_addr            = st_reg.fetch_addr;
    assign pm_rd              = st_reg.pm_rd;
    assign int_ack            = st_reg.int_ack;
    assign instruction_phases = st_reg.ph_oh;

endmodule

// ---- shared/fetch_pkg.sv ----
// constants and types for the fetch and program counter sequencer
package fetch_pkg;
    // 12, 13 or 14 according to program memory size
    localparam int PC_W      = 13;
    localparam int STK_DEPTH = 8;
    localparam int STK_IW    = 3;
    localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
    localparam logic [PC_W-1:0] IRQ_VECTOR   = 13'h0004;

    localparam logic [7:0] OFS_PCL    = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_ACC    = 8'h0C;
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_IEN_BIT  = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int STAT_PHASE_POS = 16;
    localparam int STAT_CNT_POS   = 20;
    localparam int STAT_ZERO_POS  = 24;

    // instruction class in bits 15:13, operand below
    typedef enum logic [2:0] {
        OP_ALU, OP_JUMP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN_INSTR, OP_SKZ, OP_SKNZ, OP_NOP
    } op_t;
    typedef enum logic [3:0] {
        FN_LOAD, FN_ADD, FN_SUB, FN_AND, FN_OR, FN_XOR,
        FN_RR, FN_RL, FN_INC, FN_DEC, FN_KEEP
    } alu_fn_t;
    typedef enum logic [1:0] {
        PH_FETCH, PH_DEC, PH_EXE, PH_DONE
    } phase_t;
endpackage

// ---- test/program_memory_model.sv ----
// behavioural program memory answering the fetch sequencer
`timescale 1ns/1ns
module program_memory_model
    import fetch_pkg::*;
(
    // clock
    input  wire logic            pclk,
    // fetch request and word
    input  wire logic [PC_W-1:0] pm_addr,
    input  wire logic            pm_rd,
    output logic      [15:0]     pm_data
);
    logic [15:0]     mem [0:(1<<PC_W)-1];
    logic [PC_W-1:0] addr_reg;
    logic            pend_reg;
    initial pm_data = 16'h0000;
    // data shows up one clock after the request; until then the bus
    // carries the inverse of the last word so stale data is never reused
    always @(posedge pclk) begin
        if (pm_rd === 1'b1) begin
            addr_reg <= pm_addr;
            pend_reg <= 1'b1;
            pm_data  <= ~pm_data;
        end else if (pend_reg === 1'b1) begin
            pend_reg <= 1'b0;
            pm_data  <= mem[addr_reg];
        end
    end
endmodule

// ---- test/fetch_pipeline_pc_control_monitor.sv ----
// port assertions for the fetch sequencer
`timescale 1ns/1ns
module fetch_pipeline_pc_control_monitor
    import fetch_pkg::*;
(
    // clock and reset
    input wire logic            pclk,
    input wire logic            presetn,
    // apb
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    // program memory
    input wire logic [PC_W-1:0] pm_addr,
    input wire logic            pm_rd,
    input wire logic [15:0]     pm_data,
    // misc
    input wire logic            irq_pin,
    input wire logic            int_ack,
    input wire logic [3:0]      instruction_phases
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] rot_reg;
    logic       first_reg;
    // expected next strobe pattern, registered to avoid sliced $past
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rot_reg   <= 4'h2;
            first_reg <= 1'b1;
        end else begin
            rot_reg   <= {instruction_phases[2:0], instruction_phases[3]};
            first_reg <= first_reg & ~pm_rd;
        end
    end
    sequence s_fetch_hold;
        (!pm_rd && $stable(pm_addr)) [*3];
    endsequence
    a_phase_onehot: assert property (
        $onehot(instruction_phases)) else $error("phase strobes not one-hot");
    a_phase_rotate: assert property (
        !$stable(instruction_phases) |-> instruction_phases == rot_reg)
        else $error("phase strobes skipped a phase");
    a_fetch_phase: assert property (
        pm_rd |-> instruction_phases == 4'h2) else $error("fetch off phase");
    a_fetch_start: assert property (
        $rose(instruction_phases[1]) |-> pm_rd) else $error("no fetch");
    a_addr_moves: assert property (
        !$stable(pm_addr) |-> pm_rd) else $error("address moved alone");
    a_fetch_hold: assert property (
        pm_rd |=> s_fetch_hold) else $error("fetch address not held");
    a_ready_pulse: assert property (
        psel && !penable |=> pready ##1 !pready) else $error("bad pready");
    a_pcl_upper: assert property (
        pready && !pwrite && paddr == OFS_PCL |-> prdata[31:8] == 24'h0)
        else $error("low byte read shows upper bits");
    a_reset_vector: assert property (
        pm_rd && first_reg |-> pm_addr == RESET_VECTOR)
        else $error("first fetch not at reset vector");
endmodule

bind fetch_pipeline_pc_control fetch_pipeline_pc_control_monitor i_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_data(pm_data), .irq_pin(irq_pin), .int_ack(int_ack),
    .instruction_phases(instruction_phases));

// ---- test/fetch_pipeline_pc_control_bench.sv ----
// self-checking bench for the fetch sequencer
`timescale 1ns/1ns
module fetch_pipeline_pc_control_bench
    import fetch_pkg::*;
;
    logic            pclk, presetn, psel, penable, pwrite, irq_pin;
    logic            pready, pslverr, err, pm_rd, int_ack;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic [PC_W-1:0] pm_addr;
    logic [15:0]     pm_data;
    logic [3:0]      instruction_phases;
    logic [PC_W-1:0] fq[$];
    int              mismatches, n_tests, cyc, k, n_ack;
    localparam logic [PC_W-1:0] PA [11] = '{13'h001, 13'h010, 13'h011,
        13'h012, 13'h013, 13'h014, 13'h015, 13'h020, 13'h016, 13'h110, 13'h140};
    localparam logic [15:0] PW [11] = '{16'h2010, 16'h0005, 16'hA000,
        16'h0205, 16'hA000, 16'h0001, 16'h4020, 16'h6000, 16'h2110, 16'h2110,
        16'h2140};
    localparam logic [PC_W-1:0] EXP_A [16] = '{13'h000, 13'h001, 13'h002,
        13'h010, 13'h011, 13'h012, 13'h013, 13'h014, 13'h015, 13'h016,
        13'h020, 13'h021, 13'h016, 13'h017, 13'h110, 13'h111};

    fetch_pipeline_pc_control i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data),
        .irq_pin(irq_pin), .int_ack(int_ack),
        .instruction_phases(instruction_phases));
    program_memory_model i_pm (.pclk(pclk), .pm_addr(pm_addr),
        .pm_rd(pm_rd), .pm_data(pm_data));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_fetch(input int n);
        while (fq.size() < n) @(posedge pclk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // every fetch address is logged at the edge that ends its request
    always @(posedge pclk) begin
        if (pm_rd === 1'b1) fq.push_back(pm_addr);
        if (int_ack === 1'b1) n_ack++;
    end
    // the whole run needs under two hundred clocks
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        irq_pin = 1'b0;
        for (k = 0; k < 8192; k++) i_pm.mem[k] = 16'hE000;
        for (k = 0; k < 11; k++) i_pm.mem[PA[k]] = PW[k];
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // jump, taken skip, call and return each leave one discarded slot
        wait_fetch(16);
        for (k = 0; k < 16; k++) check(fq[k], EXP_A[k]);
        $display("test sequence done");
        apb(1'b0, OFS_ACC, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[23:20], 32'h0);
        apb(1'b0, OFS_PCL, 32'h0);
        check(rd[31:1], 32'h8);
        apb(1'b0, 8'h10, 32'h0);
        check(err, 32'h1);
        check(rd, 32'h0);
        $display("test registers done");
        // upper write bits must not reach the page bits
        fq.delete();
        apb(1'b1, OFS_PCL, 32'hFFFF_FF40);
        wait_fetch(8);
        k = 0;
        while (k < 5 && fq[k][7:0] !== 8'h40) k++;
        check(fq[k], 13'h140);
        check(fq[k+1], 13'h141);
        check(fq[k+2], 13'h140);
        $display("test page jump done");
        // interrupt is taken in the dummy slot of the self jump loop
        apb(1'b1, OFS_CTRL, 32'h3);
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h3);
        fq.delete();
        irq_pin <= 1'b1;
        wait_fetch(8);
        k = 0;
        while (k < 6 && fq[k] !== 13'h004) k++;
        check(fq[k], IRQ_VECTOR);
        check(fq[k+1], 13'h005);
        check(n_ack, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[23:20], 32'h1);
        $display("test interrupt done");
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        fq.delete();
        presetn <= 1'b1;
        wait_fetch(1);
        check(fq[0], RESET_VECTOR);
        $display("test reset done");
        end_sim();
    end
endmodule
